// ===== logic/vid_pkg.sv
package vid_pkg;

  // Backplane pins seen by the chain driver, all active low except sysclk and iack_addr
  typedef struct packed {
    logic       as_n;
    logic       ds0_n;
    logic       ds1_n;
    logic       iackin_n;
    logic       dtack_n;
    logic       berr_n;
    logic       sysclk;
    logic [2:0] iack_addr;
  } vid_bus_type;

  localparam int          VID_BUS_W      = $bits(vid_bus_type);
  // Idle level of the pins: strobes negated, address zero
  localparam vid_bus_type VID_BUS_IDLE   = '{as_n: 1'b1, ds0_n: 1'b1, ds1_n: 1'b1,
                                             iackin_n: 1'b1, dtack_n: 1'b1, berr_n: 1'b1,
                                             sysclk: 1'b0, iack_addr: 3'h0};
  localparam logic        VID_NEGATED    = 1'b1;
  localparam logic        VID_ASSERTED   = 1'b0;

  // One-hot sequencer states
  typedef enum logic [7:0] {
    VID_IDLE         = 8'h01,
    VID_QUAL         = 8'h02,
    VID_PASS         = 8'h04,
    VID_VECTOR       = 8'h08,
    VID_DONE         = 8'h10,
    VID_SLOT_WAIT    = 8'h20,
    VID_SLOT_PASS    = 8'h40,
    VID_SLOT_DRIVE   = 8'h80
  } vid_state_type;

endpackage

// ===== logic/vid_iack_chain.sv
`timescale 1ns/10ps
// Function
// - Cycle start needs AS, a DS, IACKIN low with DTACK, BERR high.
// - Conditions missed on one sample are caught on the next sample.
// - Chain continues only if start conditions hold on the second sample.
// - Invalid second sample discards detection; two fresh valid samples needed.
// - Address compared only while own interrupt pending; otherwise always pass.
// - Outgoing chain driven low from a clock edge after qualification.
// - Own interrupt acknowledged: assert vector drive enable instead of passing.
// - Vector drive enable negated on DTACK low or AS high.
// - Outgoing chain released when AS returns high, every cycle type.
// - Slot identification sequence starts on a SYSCLK rising edge.
// - Non-first slot waits for IACKIN low, then pass, then drive.
// - First slot sees IACKIN low with start and proceeds at once.
// - Slot identification drives outgoing chain from a SYSCLK rising edge.
module vid_iack_chain
  import vid_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire vid_bus_type bus_pins,
  input  wire logic        irq_pending,
  input  wire logic [2:0]  own_level,
  input  wire logic        slot_identification_cycle,
  output logic             iackout_n,
  output logic             vector_drive_enable_n
);

  vid_bus_type   meta_r;
  vid_bus_type   sync_r;
  logic          sysclk_prev_r;
  vid_state_type state_r;
  logic          iackout_n_r;
  logic          vec_n_r;

  logic          start_ok;
  logic          slot_start_ok;
  logic          own_ack;
  logic          sysclk_rise;
  logic          as_high;

  // Two-stage synchroniser; bus pins are asynchronous to sys_clk
  // Bits may settle on different edges; the two-sample qualify absorbs that skew
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_r <= VID_BUS_IDLE;
      sync_r <= VID_BUS_IDLE;
    end else begin
      meta_r <= bus_pins;
      sync_r <= meta_r;
    end
  end

  // SYSCLK edge finder, reads only the second stage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sysclk_prev_r <= VID_BUS_IDLE.sysclk;
    end else begin
      sysclk_prev_r <= sync_r.sysclk;
    end
  end

  // Start decode on synchronised pins
  assign as_high       = sync_r.as_n;
  assign slot_start_ok = !sync_r.as_n && (!sync_r.ds0_n || !sync_r.ds1_n)
                         && sync_r.dtack_n && sync_r.berr_n;
  assign start_ok      = slot_start_ok && !sync_r.iackin_n;
  // Address ignored unless our own interrupter is pending
  assign own_ack       = irq_pending && (sync_r.iack_addr == own_level);
  assign sysclk_rise   = sync_r.sysclk && !sysclk_prev_r;

  // Sequencer; AS high always wins so no cycle can hang the chain
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= VID_IDLE;
    end else begin
      case (state_r)
        // Idle: slot cycles wait for a SYSCLK rise, others for one valid sample
        VID_IDLE: begin
          if (slot_identification_cycle) begin
            if (slot_start_ok && sysclk_rise) begin
              // First slot already sees IACKIN low
              state_r <= sync_r.iackin_n ? VID_SLOT_WAIT : VID_SLOT_PASS;
            end
          end else if (start_ok) begin
            state_r <= VID_QUAL;
          end
        end
        // Second sample decides: discard, own vector, or pass onward
        VID_QUAL: begin
          if (!start_ok) begin
            state_r <= VID_IDLE;
          end else if (own_ack) begin
            state_r <= VID_VECTOR;
          end else begin
            state_r <= VID_PASS;
          end
        end
        // Own vector on the bus until the handler acknowledges or ends the cycle
        VID_VECTOR: begin
          if (as_high) begin
            state_r <= VID_IDLE;
          end else if (!sync_r.dtack_n) begin
            state_r <= VID_DONE;
          end
        end
        // Later slot: hold off until the upstream board hands the chain on
        VID_SLOT_WAIT: begin
          if (as_high) begin
            state_r <= VID_IDLE;
          end else if (sysclk_rise && !sync_r.iackin_n) begin
            state_r <= VID_SLOT_PASS;
          end
        end
        // One SYSCLK period in pass before the chain is driven
        VID_SLOT_PASS: begin
          if (as_high) begin
            state_r <= VID_IDLE;
          end else if (sysclk_rise) begin
            state_r <= VID_SLOT_DRIVE;
          end
        end
        // Terminal states only leave when the address strobe goes away
        VID_PASS, VID_DONE, VID_SLOT_DRIVE: begin
          if (as_high) begin
            state_r <= VID_IDLE;
          end
        end
        // Illegal one-hot codes recover to idle rather than lock the chain
        default: begin
          state_r <= VID_IDLE;
        end
      endcase
    end
  end

  // Outgoing chain: asserted on entry to VID_PASS or VID_SLOT_DRIVE, dropped on AS high
  // AS high is tested first so a late strobe release cannot leave the chain low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      iackout_n_r <= VID_NEGATED;
    end else if (as_high) begin
      iackout_n_r <= VID_NEGATED;
    end else if (state_r == VID_QUAL && start_ok && !own_ack) begin
      iackout_n_r <= VID_ASSERTED;
    end else if (state_r == VID_SLOT_PASS && sysclk_rise) begin
      iackout_n_r <= VID_ASSERTED;
    end
  end

  // Vector enable: only from the own-ack branch, so never with the chain
  // DTACK low beats a fresh assert: the handler already holds the vector
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vec_n_r <= VID_NEGATED;
    end else if (as_high || !sync_r.dtack_n) begin
      vec_n_r <= VID_NEGATED;
    end else if (state_r == VID_QUAL && start_ok && own_ack) begin
      vec_n_r <= VID_ASSERTED;
    end
  end

  assign iackout_n             = iackout_n_r;
  assign vector_drive_enable_n = vec_n_r;

  default clocking vid_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Checks on the internal flops, sampled on sys_clk, off while in reset
  a_outputs_exclusive: assert property (
    !(!iackout_n_r && !vec_n_r))
    else $error("chain and vector enable asserted together");

  a_detect_first: assert property (
    state_r == VID_IDLE && !slot_identification_cycle && start_ok |=> state_r == VID_QUAL)
    else $error("valid start sample not detected");

  a_second_invalid: assert property (
    state_r == VID_QUAL && !start_ok |=> state_r == VID_IDLE ##1 state_r != VID_PASS)
    else $error("detection kept after invalid second sample");

  a_pass_chain: assert property (
    state_r == VID_QUAL && start_ok && !own_ack |=> !iackout_n_r && vec_n_r)
    else $error("qualified cycle not passed downstream");

  a_vector_on: assert property (
    state_r == VID_QUAL && start_ok && own_ack && sync_r.dtack_n
      |=> !vec_n_r && iackout_n_r)
    else $error("own acknowledge did not enable vector");

  a_vector_off: assert property (
    !vec_n_r && (!sync_r.dtack_n || as_high) |=> vec_n_r)
    else $error("vector enable not negated");

  a_chain_release: assert property (
    as_high |=> iackout_n_r)
    else $error("chain not released with AS high");

  a_slot_sequence: assert property (
    state_r == VID_SLOT_PASS && sysclk_rise && !as_high
      |=> state_r == VID_SLOT_DRIVE && !iackout_n_r)
    else $error("slot pass did not drive chain on SYSCLK edge");

  a_slot_hold: assert property (
    state_r == VID_SLOT_WAIT && sync_r.iackin_n |=> iackout_n_r && state_r != VID_SLOT_PASS)
    else $error("slot wait left without IACKIN");

  a_slot_start: assert property (
    state_r == VID_IDLE && slot_identification_cycle && slot_start_ok && sysclk_rise
      && !sync_r.iackin_n |=> state_r == VID_SLOT_PASS)
    else $error("first slot did not proceed at once");

  a_idle_return: assert property (
    as_high && state_r != VID_IDLE |=> state_r == VID_IDLE ##1 iackout_n_r && vec_n_r)
    else $error("no return to idle after AS high");

  // No detection without a valid sample on that edge
  a_no_false_start: assert property (
    state_r == VID_IDLE && !start_ok
      |=> state_r != VID_QUAL)
    else $error("detection without start conditions");

  // Qualify state is only entered from idle on a valid sample
  a_qual_from_idle: assert property (
    state_r == VID_QUAL
      |-> $past(state_r) == VID_IDLE && $past(start_ok))
    else $error("qualify entered without fresh sample");

  // Chain passed only after two consecutive valid samples
  a_fresh_pair: assert property (
    !slot_identification_cycle && !iackout_n_r && $past(iackout_n_r)
      |-> $past(start_ok) && $past(start_ok, 2))
    else $error("chain passed without two valid samples");

  // Vector enabled only after two valid samples for our own level
  a_vector_pair: assert property (
    !vec_n_r && $past(vec_n_r)
      |-> $past(start_ok) && $past(start_ok, 2) && $past(own_ack))
    else $error("vector enabled without qualified own cycle");

  // Nothing pending: the address never selects the vector
  a_address_ignored: assert property (
    state_r == VID_QUAL && start_ok && !irq_pending
      |=> !iackout_n_r && vec_n_r)
    else $error("address examined without own interrupt pending");

  // Pass state always shows the chain and never the vector
  a_pass_state: assert property (
    state_r == VID_PASS
      |-> !iackout_n_r && vec_n_r)
    else $error("pass state outputs wrong");

  // Vector state always shows the vector and never the chain
  a_vector_state: assert property (
    state_r == VID_VECTOR
      |-> !vec_n_r && iackout_n_r)
    else $error("vector state outputs wrong");

  // Chain stays low for as long as the strobe is held
  a_chain_holds: assert property (
    !iackout_n_r && !as_high
      |=> !iackout_n_r)
    else $error("chain output dropped before AS high");

  // Vector stays enabled until DTACK low or AS high
  a_vector_holds: assert property (
    !vec_n_r && !as_high && sync_r.dtack_n
      |=> !vec_n_r)
    else $error("vector enable dropped early");

  // After the acknowledge nothing is driven until the strobe ends
  a_done_quiet: assert property (
    state_r == VID_DONE
      |-> vec_n_r && iackout_n_r)
    else $error("outputs driven after acknowledge");

  // Idle always has both responses negated
  a_idle_quiet: assert property (
    state_r == VID_IDLE
      |-> iackout_n_r && vec_n_r)
    else $error("outputs driven while idle");

  // Slot sequence cannot start between SYSCLK rises
  a_slot_needs_clock: assert property (
    state_r == VID_IDLE && slot_identification_cycle && !sysclk_rise
      |=> state_r == VID_IDLE)
    else $error("slot sequence started without SYSCLK rise");

  // Wait state is left only on a SYSCLK rise with IACKIN low, or AS high
  a_slot_wait_exit: assert property (
    state_r == VID_SLOT_WAIT && !as_high && !(sysclk_rise && !sync_r.iackin_n)
      |=> state_r == VID_SLOT_WAIT)
    else $error("slot wait left early");

  // Wait and pass states keep both outputs negated
  a_slot_wait_quiet: assert property (
    state_r == VID_SLOT_WAIT || state_r == VID_SLOT_PASS
      |-> iackout_n_r && vec_n_r)
    else $error("outputs driven before slot drive");

  // Slot chain falls only on a SYSCLK rise out of the pass state
  a_slot_drive_clock: assert property (
    slot_identification_cycle && !iackout_n_r && $past(iackout_n_r)
      |-> $past(sysclk_rise) && $past(state_r) == VID_SLOT_PASS)
    else $error("slot chain driven off the SYSCLK rise");

  // Slot drive is released like any other cycle
  a_slot_drive_release: assert property (
    state_r == VID_SLOT_DRIVE && as_high
      |=> iackout_n_r && state_r == VID_IDLE)
    else $error("slot chain not released with AS high");

endmodule // vid_iack_chain

// ===== verification/vid_bus_model.sv
`timescale 1ns/10ps
// Interrupt handler and upstream chain neighbour as seen on the backplane
module vid_bus_model
  import vid_pkg::*;
(
  input  wire logic        sys_clk,
  output vid_bus_type      pins
);
  // Backplane clock runs free, phase unrelated to sys_clk
  initial begin
    pins = VID_BUS_IDLE;
    #37;
    forever #200 pins.sysclk = ~pins.sysclk;
  end

  // Open a cycle; m: 0 DS0, 1 DS1, 2 DTACK low, 3 BERR low, 4 glitch, 5 no DS, 6 chain high
  task automatic open_cycle(input logic [2:0] lvl, input int m);
    @(posedge sys_clk);
    pins.iack_addr <= lvl;
    pins.as_n      <= 1'b0;  // Held across the second sample
    pins.ds0_n     <= (m == 1 || m == 5);
    pins.ds1_n     <= (m != 1);
    pins.dtack_n   <= (m != 2);
    pins.berr_n    <= (m != 3);
    pins.iackin_n  <= (m == 6);
    // Glitch drops the chain input after one sample only
    if (m == 4) begin
      @(posedge sys_clk);
      pins.iackin_n <= 1'b1;
    end
  endtask

  // Responder acknowledges
  task automatic ack();
    @(posedge sys_clk);
    pins.dtack_n <= 1'b0;
  endtask

  // Upstream board hands the chain on
  task automatic chain_in();
    @(posedge sys_clk);
    pins.iackin_n <= 1'b0;
  endtask

  // Released address lines flip, so a stale value cannot pass for a driven one
  task automatic close_cycle();
    @(posedge sys_clk);
    pins.as_n      <= 1'b1;
    pins.ds0_n     <= 1'b1;
    pins.ds1_n     <= 1'b1;
    pins.dtack_n   <= 1'b1;
    pins.iackin_n  <= 1'b1;
    pins.iack_addr <= ~pins.iack_addr;
  endtask
endmodule // vid_bus_model

// ===== verification/test_vme_iack_daisy_chain_driver.sv
`timescale 1ns/10ps
// Random acknowledge cycles, then slot identification as later and first slot
module test_vme_iack_daisy_chain_driver
  import vid_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  vid_bus_type bus_pins;
  logic        irq_pending = 1'b0;
  logic [2:0]  own_level = 3'h0;
  logic        slot_identification_cycle = 1'b0;
  logic        iackout_n;
  logic        vector_drive_enable_n;
  int          err_count = 0;
  int          samples_checked = 0;
  int          seed = 96;
  int          m;
  logic [2:0]  lvl;
  logic [1:0]  want;
  logic        use_ack;

  always #25 sys_clk = ~sys_clk;

  vid_bus_model i_vid_bus_model (.sys_clk(sys_clk), .pins(bus_pins));
  vid_iack_chain i_vid_iack_chain (.sys_clk(sys_clk), .rst_n(rst_n), .bus_pins(bus_pins),
    .irq_pending(irq_pending), .own_level(own_level),
    .slot_identification_cycle(slot_identification_cycle), .iackout_n(iackout_n),
    .vector_drive_enable_n(vector_drive_enable_n));

  task automatic fail(input string s);
    err_count++;
    $display("[ERR] %0t %s", $time, s);
  endtask

  // Compare both outputs between edges
  task automatic chk(input logic [1:0] exp_v);
    @(negedge sys_clk);
    samples_checked++;
    if ({iackout_n, vector_drive_enable_n} !== exp_v) fail("chain outputs differ");
  endtask

  // Bounded wait for the chain output to go low
  task automatic wait_low();
    int n;
    n = 0;
    while (iackout_n !== 1'b0 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    samples_checked++;
    if (iackout_n !== 1'b0) fail("chain output never driven");
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Never both responses at once
  always @(negedge sys_clk) if ((iackout_n | vector_drive_enable_n) === 1'b0) fail("both low");

  // Watchdog far beyond the expected run
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail("timeout");
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // Back-to-back cycles; first six cover every start variant except chain high
    for (int i = 0; i < 40; i++) begin
      m = (i < 6) ? i : $unsigned($random(seed)) % 6;
      lvl = 3'($random(seed));
      use_ack = 1'($random(seed));
      @(posedge sys_clk);
      irq_pending <= 1'($random(seed));
      own_level <= (i % 2) ? lvl : 3'($random(seed));
      i_vid_bus_model.open_cycle(lvl, m);
      want = (m > 1) ? 2'b11 : (irq_pending && lvl == own_level) ? 2'b10 : 2'b01;
      repeat (5) @(posedge sys_clk);
      chk(want);
      if (use_ack) begin
        i_vid_bus_model.ack();
        want = (want == 2'b10) ? 2'b11 : want;
      end
      repeat (4) @(posedge sys_clk);
      chk(want);
      i_vid_bus_model.close_cycle();
      repeat (4) @(posedge sys_clk);
      chk(2'b11);
    end
    @(posedge sys_clk);
    irq_pending <= 1'b0;
    slot_identification_cycle <= 1'b1;
    i_vid_bus_model.open_cycle(3'h0, 6);
    repeat (40) @(posedge sys_clk);
    chk(2'b11);
    i_vid_bus_model.chain_in();
    wait_low();
    i_vid_bus_model.close_cycle();
    repeat (4) @(posedge sys_clk);
    chk(2'b11);
    i_vid_bus_model.open_cycle(3'h0, 0);
    wait_low();
    i_vid_bus_model.close_cycle();
    repeat (4) @(posedge sys_clk);
    chk(2'b11);
    report_and_stop();
  end
endmodule // test_vme_iack_daisy_chain_driver
